// *** logic/tric_defines.vh ***
// Constants for the tape reader input control block.
// Assumes a 25 MHz pclk; all times are turned into cycle counts here.
`ifndef TRIC_DEFINES_VH
`define TRIC_DEFINES_VH

// Clock rate
`define TRIC_CLK_MHZ 25

// Times as printed, in their own unit
`define TRIC_ACK_PULSE_NS 2000
`define TRIC_CMD_PULSE_NS 2000
`define TRIC_OFFER_DLY_NS 4400
`define TRIC_HOLD_US 2000
`define TRIC_CMD_BLOCK_US 70000
`define TRIC_PRIME_US 500000

// Cycle counts; least times round up
`define TRIC_ACK_CYC ((`TRIC_ACK_PULSE_NS * `TRIC_CLK_MHZ + 999) / 1000)
`define TRIC_CMD_CYC ((`TRIC_CMD_PULSE_NS * `TRIC_CLK_MHZ + 999) / 1000)
`define TRIC_OFFER_CYC ((`TRIC_OFFER_DLY_NS * `TRIC_CLK_MHZ + 999) / 1000)
`define TRIC_HOLD_CYC (`TRIC_HOLD_US * `TRIC_CLK_MHZ)
`define TRIC_CMD_BLOCK_CYC (`TRIC_CMD_BLOCK_US * `TRIC_CLK_MHZ)
`define TRIC_PRIME_CYC (`TRIC_PRIME_US * `TRIC_CLK_MHZ)

// Timer counter width
`define TRIC_TMR_W 24

// Register byte offsets
`define TRIC_CTRL_OFS 12'h000
`define TRIC_STAT_OFS 12'h004
`define TRIC_KEYS_OFS 12'h008

// Control register bits (write one to fire)
`define TRIC_CTRL_ARM_CANCEL 0
`define TRIC_CTRL_READ_CANCEL 1
`define TRIC_CTRL_KEYS_SET 2
`define TRIC_CTRL_KEYS_CLR 3

// Keyboard side flags register bits
`define TRIC_KEYS_WAITING 0
`define TRIC_KEYS_PERMIT 1

// Command word bits
`define TRIC_CMD_W 7
`define TRIC_CMD_DEV_BIT 3
`define TRIC_CMD_READ_BIT 5
`define TRIC_CMD_ARM_BIT 6

// Pin synchroniser vector layout
`define TRIC_SYNC_W 11
`define TRIC_PIN_ACK 0
`define TRIC_PIN_STROBE 1
`define TRIC_PIN_SPROCKET 2
`define TRIC_PIN_HEAD 3
`define TRIC_PIN_CMD_LSB 4

`endif

// *** logic/tric_timer.v ***
// One-shot cycle timer used for every fixed pulse width of the block.
// Assumes start is a same-clock pulse; a new start restarts the count.
`timescale 1ns/1ps
`default_nettype none
`include "tric_defines.vh"

module tric_timer #(
	parameter LOAD = 50
) (
	input wire pclk,
	input wire presetn,
	input wire start,
	output reg busy,
	output reg done
);
	// First count value, cut to counter width on purpose
	localparam [31:0] LOAD_M1 = LOAD - 1;

	reg [`TRIC_TMR_W-1:0] cnt_reg; // Cycles left

	// Busy lasts exactly LOAD cycles after start; done pulses once at the end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= {`TRIC_TMR_W{1'b0}};
			busy <= 1'b0;
			done <= 1'b0;
		end else if (start) begin
			cnt_reg <= LOAD_M1[`TRIC_TMR_W-1:0];
			busy <= 1'b1;
			done <= 1'b0;
		end else if (busy && cnt_reg != {`TRIC_TMR_W{1'b0}}) begin
			cnt_reg <= cnt_reg - 1'b1;
			done <= 1'b0;
		end else begin
			// Expiry
			done <= busy;
			busy <= 1'b0;
		end
	end
endmodule

`default_nettype wire

// *** logic/tric_top.v ***
// Tape reader input control: acknowledge handshake, tape feed restart,
// input register wipe, word offer and read-mode termination.
// Assumes an APB master on pclk; reader and host pins are asynchronous.
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "tric_defines.vh"

module tric_top #(
	parameter HOLD_CYC = `TRIC_HOLD_CYC,
	parameter CMD_BLOCK_CYC = `TRIC_CMD_BLOCK_CYC,
	parameter PRIME_CYC = `TRIC_PRIME_CYC
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire host_took_word,
	input wire command_word_strobe,
	input wire [`TRIC_CMD_W-1:0] command_word,
	output reg word_offer,
	output reg command_word_solicit,
	input wire sprocket,
	input wire head_lifted,
	output reg feed_strip,
	output reg reader_path_gate,
	output reg reader_motor_on,
	output reg wipe_capture_reg,
	output reg read_indicator,
	output reg armed_indicator
);
	localparam [31:0] OFFER_LAST_W = `TRIC_OFFER_CYC - 1; // Offer delay end count
	localparam [6:0] OFFER_LAST = OFFER_LAST_W[6:0]; // Cut to counter width on purpose

	// Termination word: device bit without read or arm bits
	function cmd_is_term;
		input [`TRIC_CMD_W-1:0] w;
		begin
			cmd_is_term = w[`TRIC_CMD_DEV_BIT] && !w[`TRIC_CMD_READ_BIT] &&
				!w[`TRIC_CMD_ARM_BIT];
		end
	endfunction

	// Read start word: device and read bits
	function cmd_is_read;
		input [`TRIC_CMD_W-1:0] w;
		begin
			cmd_is_read = w[`TRIC_CMD_DEV_BIT] && w[`TRIC_CMD_READ_BIT];
		end
	endfunction

	// Pin synchronisers
	wire [`TRIC_SYNC_W-1:0] pins_raw; // All asynchronous inputs
	reg [`TRIC_SYNC_W-1:0] sync1_reg; // First stage, read only by stage two
	reg [`TRIC_SYNC_W-1:0] sync2_reg; // Safe copies
	reg [`TRIC_SYNC_W-1:0] prev_reg; // For edge detection
	assign pins_raw = {command_word, head_lifted, sprocket, command_word_strobe, host_took_word};

	genvar gi;
	generate
		for (gi = 0; gi < `TRIC_SYNC_W; gi = gi + 1) begin : g_sync
			// Two flops per pin before any logic looks at it
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sync1_reg[gi] <= 1'b0;
					sync2_reg[gi] <= 1'b0;
					prev_reg[gi] <= 1'b0;
				end else begin
					sync1_reg[gi] <= pins_raw[gi];
					sync2_reg[gi] <= sync1_reg[gi];
					prev_reg[gi] <= sync2_reg[gi];
				end
			end
		end
	endgenerate

	wire ack_rise; // Host took the offered word
	wire strobe_rise; // New command word
	wire sprocket_s; // Sprocket hole under the head
	wire head_s; // Head lifted
	wire [`TRIC_CMD_W-1:0] cmd_s; // Command word after sync
	assign ack_rise = sync2_reg[`TRIC_PIN_ACK] && !prev_reg[`TRIC_PIN_ACK];
	assign strobe_rise = sync2_reg[`TRIC_PIN_STROBE] && !prev_reg[`TRIC_PIN_STROBE];
	assign sprocket_s = sync2_reg[`TRIC_PIN_SPROCKET];
	assign head_s = sync2_reg[`TRIC_PIN_HEAD];
	assign cmd_s = sync2_reg[`TRIC_SYNC_W-1:`TRIC_PIN_CMD_LSB];

	// State
	reg read_mode_reg; // Read mode latch
	reg keys_mode_reg; // Keys mode latch
	reg armed_reg; // Read armed flag
	reg primed_reg; // Reader primed flag
	reg prime_pend_reg; // Waiting for motor run-up
	reg fetch_permit_reg; // Frame fetch permit flag
	reg [`TRIC_CMD_W-1:0] cmd_reg; // Word caught at strobe
	reg init_reg; // First cycle after reset
	reg keys_waiting_reg; // Keys word waiting flag
	reg keys_permit_reg; // Keys offer permit flag
	reg arm_cancel_reg; // One-cycle button pulses
	reg read_cancel_reg;
	reg keys_set_reg;
	reg keys_clr_reg;
	reg [6:0] offer_cnt_reg; // Offer rise delay
	reg offer_ok_reg; // Delayed frame ready

	wire ack_busy; // 2 us acknowledge pulse
	wire hold_busy; // 2 ms stretched pulse
	wire cmd_busy; // 2 us command pulse
	wire block_busy; // 70 ms solicit block
	wire prime_done; // Motor run-up elapsed
	wire read_rise; // Read mode starting

	// Acknowledge pulse and stretch both start on the same edge
	tric_timer #(.LOAD(`TRIC_ACK_CYC)) u_ack (
		.pclk(pclk), .presetn(presetn), .start(ack_rise),
		.busy(ack_busy), .done()
	);
	tric_timer #(.LOAD(HOLD_CYC)) u_hold (
		.pclk(pclk), .presetn(presetn), .start(ack_rise),
		.busy(hold_busy), .done()
	);
	tric_timer #(.LOAD(`TRIC_CMD_CYC)) u_cmd (
		.pclk(pclk), .presetn(presetn), .start(strobe_rise),
		.busy(cmd_busy), .done()
	);
	// Reset acts like master clear and also blocks solicits for 70 ms
	tric_timer #(.LOAD(CMD_BLOCK_CYC)) u_block (
		.pclk(pclk), .presetn(presetn), .start(strobe_rise || init_reg),
		.busy(block_busy), .done()
	);
	tric_timer #(.LOAD(PRIME_CYC)) u_prime (
		.pclk(pclk), .presetn(presetn), .start(read_rise),
		.busy(), .done(prime_done)
	);

	// Mode and flag next values
	reg read_mode_next;
	reg keys_mode_next;
	reg armed_next;
	wire term_cmd; // Host termination
	wire read_cmd; // Host read start
	wire head_hold; // Head lift clear, once block is over
	assign term_cmd = cmd_busy && cmd_is_term(cmd_reg);
	assign read_cmd = cmd_busy && cmd_is_read(cmd_reg);
	assign head_hold = head_s && !block_busy;
	assign read_rise = read_mode_next && !read_mode_reg;

	// Latches: clears first, so a same-cycle set still wins, except head hold or leaving read mode clears armed last
	always @* begin
		read_mode_next = read_mode_reg;
		keys_mode_next = keys_mode_reg;
		if (term_cmd || read_cancel_reg) begin
			read_mode_next = 1'b0;
			keys_mode_next = 1'b0;
		end
		if (keys_clr_reg)
			keys_mode_next = 1'b0;
		if (read_cmd) begin
			read_mode_next = 1'b1;
			keys_mode_next = 1'b0;
		end else if (keys_set_reg && !read_mode_next) begin
			keys_mode_next = 1'b1;
		end
		armed_next = armed_reg;
		if (arm_cancel_reg)
			armed_next = 1'b0;
		if (read_cmd && cmd_reg[`TRIC_CMD_ARM_BIT])
			armed_next = 1'b1;
		// Head hold and leaving read mode override everything
		if (!read_mode_next || head_hold)
			armed_next = 1'b0;
	end

	// Frame ready: primed and not feeding
	wire frame_ready;
	reg feed_next;
	reg gate_next;
	reg offer_next;
	reg wipe_next;
	// Head up also kills the frame, so no offer is made while the head is lifted
	assign frame_ready = primed_reg && !feed_strip && !head_s;

	// Reader and host side outputs
	always @* begin
		// Feed while permit clear, or until sprocket once set
		feed_next = read_mode_reg && primed_reg && !head_s &&
			!(fetch_permit_reg && sprocket_s);
		gate_next = read_mode_reg && !head_s && sprocket_s &&
			fetch_permit_reg;
		offer_next = offer_ok_reg && read_mode_reg && armed_reg &&
			!(feed_strip && !keys_permit_reg);
		wipe_next = !frame_ready && !ack_busy && !ack_rise &&
			!keys_waiting_reg;
	end

	// Core state registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			read_mode_reg <= 1'b0;
			keys_mode_reg <= 1'b0;
			armed_reg <= 1'b0;
			primed_reg <= 1'b0;
			prime_pend_reg <= 1'b0;
			fetch_permit_reg <= 1'b1; // Master clear sets it
			cmd_reg <= {`TRIC_CMD_W{1'b0}};
			init_reg <= 1'b1;
		end else begin
			init_reg <= 1'b0;
			read_mode_reg <= read_mode_next;
			keys_mode_reg <= keys_mode_next;
			armed_reg <= armed_next;
			if (strobe_rise)
				cmd_reg <= cmd_s;
			// Primed after motor run-up, lost when read ends
			if (!read_mode_next) begin
				primed_reg <= 1'b0;
				prime_pend_reg <= 1'b0;
			end else if (read_rise) begin
				prime_pend_reg <= 1'b1;
			end else if (prime_pend_reg && prime_done) begin
				primed_reg <= 1'b1;
				prime_pend_reg <= 1'b0;
			end
			// Permit cleared on ack edge and held for 2 ms
			if (ack_rise || hold_busy)
				fetch_permit_reg <= 1'b0;
			else if (!sprocket_s && primed_reg)
				fetch_permit_reg <= 1'b1;
		end
	end

	// Offer delay: counts up while ready, drops at once when not
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			offer_cnt_reg <= 7'h00;
			offer_ok_reg <= 1'b0;
		end else if (!frame_ready) begin
			offer_cnt_reg <= 7'h00;
			offer_ok_reg <= 1'b0;
		end else if (offer_cnt_reg == OFFER_LAST) begin
			offer_ok_reg <= 1'b1;
		end else begin
			offer_cnt_reg <= offer_cnt_reg + 7'h01;
		end
	end

	// Output flops; every pin output is registered
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			feed_strip <= 1'b0;
			reader_path_gate <= 1'b0;
			reader_motor_on <= 1'b0;
			wipe_capture_reg <= 1'b0;
			word_offer <= 1'b0;
			command_word_solicit <= 1'b0;
			read_indicator <= 1'b0;
			armed_indicator <= 1'b0;
		end else begin
			feed_strip <= feed_next;
			reader_path_gate <= gate_next;
			reader_motor_on <= read_mode_reg;
			wipe_capture_reg <= wipe_next;
			word_offer <= offer_next;
			command_word_solicit <= !block_busy && !strobe_rise && !init_reg;
			read_indicator <= read_mode_reg;
			armed_indicator <= armed_reg;
		end
	end

	// APB decode
	wire apb_setup; // First cycle of a transfer
	wire apb_write; // Write takes effect here
	wire hit_ctrl;
	wire hit_stat;
	wire hit_keys;
	assign apb_setup = psel && !penable;
	assign apb_write = psel && penable && pwrite;
	assign hit_ctrl = (paddr == `TRIC_CTRL_OFS);
	assign hit_stat = (paddr == `TRIC_STAT_OFS);
	assign hit_keys = (paddr == `TRIC_KEYS_OFS);

	// Register writes; button bits are one-cycle pulses
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			keys_waiting_reg <= 1'b0;
			keys_permit_reg <= 1'b0;
			arm_cancel_reg <= 1'b0;
			read_cancel_reg <= 1'b0;
			keys_set_reg <= 1'b0;
			keys_clr_reg <= 1'b0;
		end else begin
			arm_cancel_reg <= apb_write && hit_ctrl && pwdata[`TRIC_CTRL_ARM_CANCEL];
			read_cancel_reg <= apb_write && hit_ctrl && pwdata[`TRIC_CTRL_READ_CANCEL];
			keys_set_reg <= apb_write && hit_ctrl && pwdata[`TRIC_CTRL_KEYS_SET];
			keys_clr_reg <= apb_write && hit_ctrl && pwdata[`TRIC_CTRL_KEYS_CLR];
			if (apb_write && hit_keys) begin
				keys_waiting_reg <= pwdata[`TRIC_KEYS_WAITING];
				keys_permit_reg <= pwdata[`TRIC_KEYS_PERMIT];
			end
		end
	end

	// Read data and error prepared in setup, valid through access
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= 1'b1; // Zero wait states
			if (apb_setup) begin
				pslverr <= !(hit_ctrl || hit_stat || hit_keys);
				if (hit_stat)
					prdata <= {23'h000000, head_s, block_busy, word_offer, feed_strip,
						fetch_permit_reg, primed_reg, armed_reg, keys_mode_reg,
						read_mode_reg};
				else if (hit_keys)
					prdata <= {30'h00000000, keys_permit_reg, keys_waiting_reg};
				else
					prdata <= 32'h0000_0000;
			end
		end
	end
endmodule

`default_nettype wire

// *** bench/tric_props.sv ***
// Pin checker for the reader input control block.
// Assumes bind onto tric_top; keys flags stay clear.
`timescale 1ns/1ps
`default_nettype none
module tric_props #(
	parameter CMD_BLOCK_CYC = 40
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic host_took_word,
	input wire logic command_word_strobe,
	input wire logic head_lifted,
	input wire logic word_offer,
	input wire logic command_word_solicit,
	input wire logic feed_strip,
	input wire logic reader_path_gate,
	input wire logic reader_motor_on,
	input wire logic wipe_capture_reg,
	input wire logic read_indicator,
	input wire logic armed_indicator
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [15:0] low_cnt; // Cycles with solicit low
	// Count the blocked span; wide enough for any shortened block
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			low_cnt <= 16'h0000;
		else if (command_word_solicit)
			low_cnt <= 16'h0000;
		else
			low_cnt <= low_cnt + 16'h0001;
	end
	// Strobe edge at the pin
	sequence s_strobe;
		$rose(command_word_strobe);
	endsequence
	// Read mode exit seen on the motor line
	sequence s_exit;
		$fell(reader_motor_on);
	endsequence
	a_strobe_blocks: assert property (s_strobe |-> ##[2:8] !command_word_solicit)
		else $error("solicit not blocked");
	a_block_len: assert property ($rose(command_word_solicit) |-> low_cnt >= CMD_BLOCK_CYC - 2)
		else $error("block too short");
	a_ack_drop_offer: assert property ($rose(host_took_word) && word_offer |-> ##[1:8] !word_offer)
		else $error("offer held after ack");
	a_ack_feed: assert property ($rose(host_took_word) && reader_path_gate |-> ##[2:8] feed_strip)
		else $error("no feed after ack");
	a_feed_gate_excl: assert property (!(feed_strip && reader_path_gate))
		else $error("feed with gate");
	a_offer_gate: assert property ($rose(word_offer) |-> reader_path_gate)
		else $error("offer without data");
	a_unarmed_quiet: assert property (!armed_indicator && !word_offer |=> !word_offer)
		else $error("offer while unarmed");
	a_head_stop: assert property ($rose(head_lifted) |-> ##[2:6] !feed_strip)
		else $error("feed with head up");
	a_exit_drop: assert property (s_exit |-> ##[0:2] (!read_indicator && !reader_path_gate
		&& !armed_indicator && !feed_strip))
		else $error("exit left outputs on");
	a_exit_wipe: assert property (s_exit ##0 !host_took_word |-> ##[0:4] wipe_capture_reg)
		else $error("no wipe after exit");
endmodule
bind tric_top tric_props #(.CMD_BLOCK_CYC(CMD_BLOCK_CYC)) i_tric_props (.pclk, .presetn,
	.host_took_word, .command_word_strobe, .head_lifted, .word_offer, .command_word_solicit,
	.feed_strip, .reader_path_gate, .reader_motor_on, .wipe_capture_reg, .read_indicator,
	.armed_indicator);
`default_nettype wire

// *** bench/tric_host_model.sv ***
// Host computer model: command words and word acknowledges.
// Assumes the bench sets lag and calls send_cmd.
`timescale 1ns/1ps
`default_nettype none
`include "tric_defines.vh"
module tric_host_model (
	input wire logic pclk,
	input wire logic word_offer,
	output var logic host_took_word,
	output var logic command_word_strobe,
	output var logic [`TRIC_CMD_W-1:0] command_word
);
	int lag = 2; // Cycles before the host answers
	int n; // Bound on the offer release wait
	// Acknowledge each stored word, then wait for the offer to clear
	initial begin
		host_took_word = 1'b0;
		command_word_strobe = 1'b0;
		command_word = 7'h00;
		forever begin
			@(posedge pclk);
			if (word_offer === 1'b1) begin
				repeat (lag) @(posedge pclk);
				host_took_word <= 1'b1;
				repeat (4) @(posedge pclk);
				host_took_word <= 1'b0;
				for (n = 0; n < 50 && word_offer === 1'b1; n++) @(posedge pclk);
			end
		end
	end
	// Word is held around the strobe; afterwards the lines show junk
	task send_cmd(input logic [`TRIC_CMD_W-1:0] w);
		@(posedge pclk);
		command_word <= w;
		repeat (3) @(posedge pclk);
		command_word_strobe <= 1'b1;
		repeat (4) @(posedge pclk);
		command_word_strobe <= 1'b0;
		repeat (3) @(posedge pclk);
		command_word <= ~w;
	endtask
endmodule
`default_nettype wire

// *** bench/tb_tric_top.sv ***
// Self-checking bench for the reader input control block.
// Assumes shortened hold, block and prime counts.
`timescale 1ns/1ps
`default_nettype none
`include "tric_defines.vh"
module tb_tric_top;
	localparam int OFR = 0, SOL = 1, FED = 2, GAT = 3, MOT = 4, WIP = 5, ARM = 6;
	logic pclk = 1'b0, presetn = 1'b0; // Clock and reset
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, rd_err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic sprocket = 1'b0, head_lifted = 1'b0; // Reader pins
	logic host_took_word, command_word_strobe, word_offer, command_word_solicit;
	logic [`TRIC_CMD_W-1:0] command_word;
	logic feed_strip, reader_path_gate, reader_motor_on, wipe_capture_reg;
	logic read_indicator, armed_indicator;
	int miscompares = 0, cmp_count = 0, seed = 32'h77d5, f, exp_rd, exp_arm;
	wire [6:0] ob = {armed_indicator, wipe_capture_reg, reader_motor_on, reader_path_gate,
		feed_strip, command_word_solicit, word_offer};
	always #20 pclk = ~pclk;
	tric_top #(.HOLD_CYC(20), .CMD_BLOCK_CYC(40), .PRIME_CYC(30)) i_tric_top (.pclk,
		.presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.host_took_word, .command_word_strobe, .command_word, .word_offer,
		.command_word_solicit, .sprocket, .head_lifted, .feed_strip, .reader_path_gate,
		.reader_motor_on, .wipe_capture_reg, .read_indicator, .armed_indicator);
	tric_host_model i_tric_host_model (.pclk, .word_offer, .host_took_word,
		.command_word_strobe, .command_word);
	task report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Bounded wait for one output to reach a level
	task wt(input int b, input logic v, input int lim);
		int n;
		for (n = 0; n < lim && ob[b] !== v; n++) @(posedge pclk);
		chk($sformatf("out%0d", b), {31'h0, ob[b]}, {31'h0, v});
		if (ob[b] !== v) report_and_stop();
	endtask
	// One APB transfer; data and error taken at the ready edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 16; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		rd_err = pslverr;
		chk("pready", {31'h0, pready}, 32'h1);
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 16) report_and_stop();
	endtask
	// Reader pin levels, both changed on one edge
	task pins(input logic s, input logic h);
		sprocket <= s;
		head_lifted <= h;
	endtask
	// Hang guard
	initial begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		report_and_stop();
	end
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		chk("solicit", {31'h0, command_word_solicit}, 32'h0);
		apb(1'b0, 12'h00c, 32'h0);
		chk("unmapped", {rd_err, rd[30:0]}, 32'h80000000);
		apb(1'b1, `TRIC_KEYS_OFS, ($random(seed) & 32'hfffffffc) | 32'h2);
		apb(1'b0, `TRIC_KEYS_OFS, 32'h0);
		chk("keys", rd, 32'h2);
		apb(1'b1, `TRIC_KEYS_OFS, 32'h0);
		wt(SOL, 1'b1, 100);
		i_tric_host_model.send_cmd(7'o150);
		exp_rd = 1;
		exp_arm = 1;
		wt(SOL, 1'b0, 10);
		wt(MOT, 1'b1, 20);
		chk("read", {31'h0, read_indicator}, exp_rd);
		chk("armed", {31'h0, armed_indicator}, exp_arm);
		apb(1'b0, `TRIC_STAT_OFS, 32'h0);
		chk("modes", rd[1:0], 2'b01);
		wt(FED, 1'b1, 200);
		for (f = 0; f < 3; f++) begin
			i_tric_host_model.lag = ($random(seed) & 7) + 1;
			pins(1'b1, 1'b0);
			wt(GAT, 1'b1, 20);
			chk("feed", {31'h0, feed_strip}, 32'h0);
			wt(OFR, 1'b1, 200);
			wt(OFR, 1'b0, 40);
			wt(FED, 1'b1, 20);
			pins(1'b0, 1'b0);
			wt(WIP, 1'b1, 80);
			repeat (30) @(posedge pclk);
			chk("feed", {31'h0, feed_strip}, 32'h1);
		end
		pins(1'b0, 1'b1);
		wt(FED, 1'b0, 10);
		wt(ARM, 1'b0, 10);
		pins(1'b1, 1'b0);
		repeat (150) @(posedge pclk);
		chk("offer", {31'h0, word_offer}, 32'h0);
		pins(1'b0, 1'b0);
		i_tric_host_model.send_cmd(7'o151);
		wt(ARM, 1'b1, 20);
		// Lift inside the 40-cycle block must leave the armed flag alone
		pins(1'b0, 1'b1);
		repeat (8) @(posedge pclk);
		chk("armed", {31'h0, armed_indicator}, 32'h1);
		pins(1'b0, 1'b0);
		// Command pulse keeps setting the flag; cancel only after it ends
		repeat (`TRIC_CMD_CYC) @(posedge pclk);
		apb(1'b1, `TRIC_CTRL_OFS, 32'h1);
		wt(ARM, 1'b0, 10);
		i_tric_host_model.send_cmd(7'o010);
		wt(MOT, 1'b0, 20);
		chk("read", {31'h0, read_indicator}, 32'h0);
		chk("gate", {30'h0, reader_path_gate, feed_strip}, 32'h0);
		wt(WIP, 1'b1, 10);
		i_tric_host_model.send_cmd(7'o150);
		wt(MOT, 1'b1, 20);
		repeat (`TRIC_CMD_CYC) @(posedge pclk);
		apb(1'b1, `TRIC_CTRL_OFS, 32'h2);
		wt(MOT, 1'b0, 10);
		apb(1'b0, `TRIC_STAT_OFS, 32'h0);
		chk("modes", rd[1:0], 2'b00);
		apb(1'b0, `TRIC_CTRL_OFS, 32'h0);
		chk("ctrl", rd, 32'h0);
		report_and_stop();
	end
endmodule
`default_nettype wire
